// >>> src/egp_port.sv
// Eight-bit general-purpose port with direction and level registers.
// Assumes a simple peripheral bus: word address, read and write strobes,
// read data valid one cycle after the read strobe.
//
// Behaviour
// - Eight pins, each input or output
// - CPU and DMA reach registers via bus
// - Direction register at 0x3400
// - Level register at 0x3401
// - Pins 3 and 5 shared with serial
// - Strap low: shared pins are port pins
// - Strap high: shared pins serve serial port
// - Selection latched at reset release, then fixed
// - Direction bit: 0 input, 1 output, reset 0
// - Input pins read their sampled level
// - Output pins drive written level
// - After reset level reads pin levels
`default_nettype none
module egp_port
  import egp_pkg::*;
(
  input wire logic clk, // 200 MHz peripheral clock
  input wire logic rst, // Synchronous reset, high
  input wire logic [EGP_AW-1:0] bus_addr, // Word address
  input wire logic bus_wr, // Write strobe, one cycle
  input wire logic bus_rd, // Read strobe, one cycle
  input wire logic [EGP_DW-1:0] bus_wdata, // Write data
  output logic [EGP_DW-1:0] bus_rdata, // Read data, registered
  output logic bus_rvalid, // Read data valid pulse
  input wire logic [EGP_PINS-1:0] pin_in, // Pin levels
  output logic [EGP_PINS-1:0] pin_out, // Pin drive levels
  output logic [EGP_PINS-1:0] pin_oe, // Pin drive enables
  output logic serial_mode // 1: shared pins serve serial port
);
  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [7:0] dir;      // Direction bits
    logic [7:0] out;      // Output latch
    logic [15:0] rdata;   // Read data
    logic rvalid;         // Read answer
    logic in_rst;         // Reset seen last cycle
    logic strap;          // Shared-pin selection
  } egp_state_t;
  egp_state_t s_q, s_d;
  logic [7:0] lvl; // Registered pin levels
  logic [7:0] cell_oe; // Raw enables from cells
  logic [7:0] cell_out; // Raw drive from cells
  logic [7:0] lvl_view; // Level register read view
  logic [7:0] drive_dir; // Enables handed to the cells
  logic [7:0] drive_val; // Levels handed to the cells

  ////////////////////////////////////////////////////////////////////////////
  // Shared-pin masking
  // In serial mode pins 3 and 5 belong to the serial transmitter, so their
  // cells get a zero enable and a zero level. Masking ahead of the cell flops
  // keeps every pin output a flop output. The price is one cycle of lag, which
  // never shows: the strap only moves at reset release, when every direction
  // bit is still clear.
  always_comb begin
    drive_dir = s_q.dir;
    drive_val = s_q.out;
    if (s_q.strap) begin
      drive_dir[EGP_SHARE_A] = 1'b0;
      drive_dir[EGP_SHARE_B] = 1'b0;
      drive_val[EGP_SHARE_A] = 1'b0; // Serial port owns the level
      drive_val[EGP_SHARE_B] = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin cells
  // Each cell registers its enable, its drive level and the sampled pin level
  genvar gi;
  generate
    for (gi = 0; gi < EGP_PINS; gi++) begin : g_pin
      egp_pin_cell u_cell (
        .clk(clk),
        .rst(rst),
        .dir_out(drive_dir[gi]),
        .out_val(drive_val[gi]),
        .pad_in(pin_in[gi]),
        .pad_out(cell_out[gi]),
        .pad_oe(cell_oe[gi]),
        .lvl(lvl[gi])
      );
    end
  endgenerate

  // Output pins read their latch, inputs their sampled level
  assign lvl_view = (s_q.dir & s_q.out) | (~s_q.dir & lvl);

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  // Writes land at the strobe edge; reads answer one cycle later with a
  // single-cycle valid. A write and a read in one cycle read the old value,
  // since the answer is built from the current registers.
  always_comb begin
    s_d = s_q;
    s_d.rvalid = 1'b0;
    s_d.in_rst = rst;
    // Strap caught on the first cycle after reset release, held until the next reset release
    if (s_q.in_rst && !rst) begin
      s_d.strap = pin_in[EGP_STRAP_BIT];
    end
    // Writes; the upper byte is discarded
    if (bus_wr) begin
      if (bus_addr == EGP_DIR_ADDR) begin
        s_d.dir = bus_wdata[7:0];
      end else if (bus_addr == EGP_LVL_ADDR) begin
        s_d.out = bus_wdata[7:0];
      end
    end
    // Reads, answered the next cycle
    if (bus_rd) begin
      s_d.rvalid = 1'b1;
      if (bus_addr == EGP_DIR_ADDR) begin
        s_d.rdata = {EGP_RSVD_RD, s_q.dir};
      end else if (bus_addr == EGP_LVL_ADDR) begin
        s_d.rdata = {EGP_RSVD_RD, lvl_view};
      end else begin
        s_d.rdata = EGP_UNMAPPED_RD;
      end
    end
    if (rst) begin
      s_d.dir = EGP_DIR_RST;
      s_d.out = EGP_OUT_RST;
      s_d.rdata = '0;
      s_d.rvalid = 1'b0;
      s_d.strap = s_q.strap;
    end
  end

  // State register; strap holds over reset until release samples it.
  // The strap has no reset value of its own: it is unknown until the first
  // release, and software must not rely on the shared pins before then.
  // No reset branch here: reset is handled in the next-state logic above.
  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs: all straight from flops
  // Shared pins were already masked ahead of the cells in serial mode
  assign pin_out = cell_out;
  assign pin_oe = cell_oe;
  assign bus_rdata = s_q.rdata;
  assign bus_rvalid = s_q.rvalid;
  assign serial_mode = s_q.strap;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  // All checks run on the one clock and stand down while reset is high,
  // except those that describe what reset itself must do.
  chk_dir_write: assert property (@(posedge clk) disable iff (rst)
    bus_wr && bus_addr == EGP_DIR_ADDR |=> s_q.dir == $past(bus_wdata[7:0]))
    else $error("direction write lost");
  chk_rsvd_zero: assert property (@(posedge clk) disable iff (rst)
    bus_rvalid |-> bus_rdata[15:8] == 8'h00)
    else $error("reserved bits not zero");
  chk_read_dir: assert property (@(posedge clk) disable iff (rst)
    bus_rd && bus_addr == EGP_DIR_ADDR |=> bus_rvalid && bus_rdata[7:0] == $past(s_q.dir))
    else $error("direction read wrong");
  chk_read_lvl: assert property (@(posedge clk) disable iff (rst)
    bus_rd && bus_addr == EGP_LVL_ADDR |=> bus_rdata[7:0] == $past(lvl_view))
    else $error("level read wrong");
  chk_input_lvl: assert property (@(posedge clk) disable iff (rst)
    s_q.dir == 8'h00 |-> ##1 lvl == $past(pin_in))
    else $error("input level not sampled");
  chk_drive_pin: assert property (@(posedge clk) disable iff (rst)
    !s_q.strap && $stable(s_q.dir) && $stable(s_q.out) |=> pin_oe == $past(s_q.dir)
      && (pin_out & pin_oe) == ($past(s_q.out) & pin_oe))
    else $error("pin drive wrong");
  chk_strap_fixed: assert property (@(posedge clk) disable iff (rst)
    !$past(s_q.in_rst) |-> $stable(s_q.strap))
    else $error("strap changed outside reset");
  chk_strap_take: assert property (@(posedge clk)
    $fell(rst) |=> s_q.strap == $past(pin_in[EGP_STRAP_BIT]))
    else $error("strap not taken");
  chk_serial_off: assert property (@(posedge clk) disable iff (rst)
    serial_mode |-> !pin_oe[EGP_SHARE_A] && !pin_oe[EGP_SHARE_B])
    else $error("shared pin driven in serial mode");
  chk_rst_dir: assert property (@(posedge clk)
    rst |=> s_q.dir == 8'h00)
    else $error("direction not reset");
  // Register traffic
  chk_lvl_write: assert property (@(posedge clk) disable iff (rst)
    bus_wr && bus_addr == EGP_LVL_ADDR |=> s_q.out == $past(bus_wdata[7:0]))
    else $error("level latch write lost");
  chk_answer_once: assert property (@(posedge clk) disable iff (rst)
    bus_rvalid |-> $past(bus_rd))
    else $error("read answer without request");
  chk_rdata_hold: assert property (@(posedge clk) disable iff (rst)
    !bus_rd |=> $stable(bus_rdata))
    else $error("read data moved without read");
  chk_unmapped_zero: assert property (@(posedge clk) disable iff (rst)
    bus_rd && bus_addr != EGP_DIR_ADDR && bus_addr != EGP_LVL_ADDR
      |=> bus_rvalid && bus_rdata == EGP_UNMAPPED_RD)
    else $error("unmapped read not zero");
  chk_dir_hold: assert property (@(posedge clk) disable iff (rst)
    !(bus_wr && bus_addr == EGP_DIR_ADDR) |=> $stable(s_q.dir))
    else $error("direction moved without write");
  chk_out_hold: assert property (@(posedge clk) disable iff (rst)
    !(bus_wr && bus_addr == EGP_LVL_ADDR) |=> $stable(s_q.out))
    else $error("output latch moved without write");
  // Level register contents, input pins against the pins two cycles back
  chk_input_read: assert property (@(posedge clk) disable iff (rst)
    bus_rd && bus_addr == EGP_LVL_ADDR |=> (bus_rdata[7:0] & ~$past(s_q.dir))
      == ($past(pin_in, 2) & ~$past(s_q.dir)))
    else $error("input pin read wrong");
  chk_output_read: assert property (@(posedge clk) disable iff (rst)
    bus_rd && bus_addr == EGP_LVL_ADDR |=> (bus_rdata[7:0] & $past(s_q.dir))
      == ($past(s_q.out) & $past(s_q.dir)))
    else $error("output pin read wrong");
  chk_rst_quiet: assert property (@(posedge clk)
    rst |=> pin_oe == 8'h00 && !bus_rvalid)
    else $error("pins or answer active in reset");
  chk_serial_level: assert property (@(posedge clk) disable iff (rst)
    serial_mode |-> !pin_out[EGP_SHARE_A] && !pin_out[EGP_SHARE_B])
    else $error("shared pin level set in serial mode");
  cov_dir_write: cover property (@(posedge clk) bus_wr && bus_addr == EGP_DIR_ADDR);
  cov_lvl_read: cover property (@(posedge clk) bus_rd && bus_addr == EGP_LVL_ADDR);
  cov_serial: cover property (@(posedge clk) $rose(serial_mode));
  cov_shared_port: cover property (@(posedge clk) !serial_mode && pin_oe[EGP_SHARE_A]);
endmodule
`default_nettype wire

// >>> src/egp_pkg.sv
// Package for the eight-bit general-purpose port: addresses, widths, reset values.
// Assumes a 16-bit peripheral bus with word addresses and one-cycle strobes.
`default_nettype none
package egp_pkg;
  localparam int unsigned EGP_PINS = 8; // Pins in the port
  localparam int unsigned EGP_AW = 16; // Peripheral word address width
  localparam int unsigned EGP_DW = 16; // Peripheral data width
  localparam logic [15:0] EGP_DIR_ADDR = 16'h3400; // Direction register
  localparam logic [15:0] EGP_LVL_ADDR = 16'h3401; // Level register
  localparam logic [7:0] EGP_DIR_RST = 8'h00; // All pins input after reset
  localparam logic [7:0] EGP_OUT_RST = 8'h00; // Output latch after reset
  localparam logic [7:0] EGP_RSVD_RD = 8'h00; // Upper byte reads zero
  localparam int unsigned EGP_STRAP_BIT = 7; // Pin that straps the shared pins
  localparam int unsigned EGP_SHARE_A = 3; // Port pin on shared pin a
  localparam int unsigned EGP_SHARE_B = 5; // Port pin on shared pin b
  localparam logic [15:0] EGP_UNMAPPED_RD = 16'h0000; // Answer for other addresses
endpackage
`default_nettype wire

// >>> src/egp_pin_cell.sv
// One port pin: output drive, enable and input sampling.
// Assumes the pad resolves the wire from the enable; input is synchronous.
`default_nettype none
module egp_pin_cell
  import egp_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic rst, // Synchronous reset, high
  input wire logic dir_out, // 1 drives the pin
  input wire logic out_val, // Level to drive
  input wire logic pad_in, // Level seen on the pin
  output logic pad_out, // Level driven on the pin
  output logic pad_oe, // High while driving
  output logic lvl // Registered pin level
);
  typedef struct packed {
    logic out;
    logic oe;
    logic lvl;
  } egp_cell_t;
  egp_cell_t s_q, s_d;

  // Next state: drive and sample
  always_comb begin
    s_d = s_q;
    s_d.oe = dir_out;
    s_d.out = out_val;
    s_d.lvl = pad_in;
    if (rst) begin
      s_d.oe = 1'b0;
      s_d.out = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  assign pad_out = s_q.out;
  assign pad_oe = s_q.oe;
  assign lvl = s_q.lvl;
endmodule
`default_nettype wire

// >>> sim/egp_pins_model.sv
// Far-side model: the wires seen by the port pins.
// Assumes a driven pin follows the port and an undriven pin the outside level.
`default_nettype none
module egp_pins_model (
  input wire logic [7:0] pin_out, // Port drive level
  input wire logic [7:0] pin_oe, // Port drive enable
  input wire logic [7:0] ext_lvl, // Outside driver level
  output logic [7:0] pin_in // Resolved wire level
);
  timeunit 1ns;
  timeprecision 100ps;
  // Port owns a wire only while enabled, so no contention is modelled
  assign pin_in = (pin_out & pin_oe) | (ext_lvl & ~pin_oe);
endmodule
`default_nettype wire

// >>> sim/egp_port_tb.sv
// Bench for the port: bus tasks, pin model and an integer reference.
// Assumes inputs change at the falling edge of clk.
`default_nettype none
module egp_port_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import egp_pkg::*;
  logic clk, rst = 1'b1, bus_wr = 1'b0, bus_rd = 1'b0, bus_rvalid, serial_mode;
  logic [15:0] bus_addr = 16'h0000, bus_wdata = 16'h0000, bus_rdata;
  logic [7:0] pin_in, pin_out, pin_oe, ext = 8'h00;
  int err_count = 0, compares = 0, cyc = 0, dir_m, out_m, lvl_m;
  egp_port egp_port_i (.clk(clk), .rst(rst), .bus_addr(bus_addr), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .serial_mode(serial_mode));
  egp_pins_model egp_pins_model_i (.pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext),
    .pin_in(pin_in));
  ////////////////////////////////////////////////////////////////////////////////
  // Clock at 200 MHz
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Hang guard: the whole run needs well under this
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
    @(negedge clk) {bus_wr, bus_addr, bus_wdata} = {1'b1, a, d};
    @(negedge clk) bus_wr = 1'b0;
  endtask
  // Read with a bounded wait on the answer pulse
  task automatic rd_reg(input logic [15:0] a, input logic [15:0] exp);
    int n;
    @(negedge clk) {bus_rd, bus_addr} = {1'b1, a};
    @(negedge clk) bus_rd = 1'b0;
    for (n = 0; n < 4 && bus_rvalid !== 1'b1; n++) @(negedge clk);
    chk({15'h0000, bus_rvalid}, 16'h0001);
    chk(bus_rdata, exp);
  endtask
  // Strap pin 7 during reset, then flip it to show the choice stays put
  task automatic do_reset(input logic strap);
    @(negedge clk) rst = 1'b1;
    ext[7] = strap;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    ext[7] = ~strap;
    @(negedge clk);
  endtask
  task automatic report_and_stop();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    dir_m = $urandom(32'hADF5);
    do_reset(1'b1);
    chk({15'h0000, serial_mode}, 16'h0001);
    wr_reg(EGP_DIR_ADDR, 16'hFFFF);
    wr_reg(EGP_LVL_ADDR, 16'hFFFF);
    repeat (2) @(negedge clk);
    chk({8'h00, pin_oe}, 16'h00D7);
    chk({8'h00, pin_out}, 16'h00D7);
    rd_reg(EGP_DIR_ADDR, 16'h00FF);
    rd_reg(EGP_LVL_ADDR, 16'h00FF);
    do_reset(1'b0);
    chk({15'h0000, serial_mode}, 16'h0000);
    rd_reg(EGP_DIR_ADDR, 16'h0000);
    rd_reg(EGP_LVL_ADDR, {8'h00, ext});
    rd_reg(16'h3402, EGP_UNMAPPED_RD);
    // Random directions, latches and outside levels against the reference
    repeat (24) begin
      dir_m = $urandom;
      out_m = $urandom;
      ext = 8'($urandom);
      wr_reg(EGP_DIR_ADDR, dir_m[15:0]);
      wr_reg(EGP_LVL_ADDR, out_m[15:0]);
      dir_m = dir_m & 255;
      out_m = out_m & 255;
      repeat (2) @(negedge clk);
      chk({8'h00, pin_oe}, dir_m[15:0]);
      chk({8'h00, pin_out & pin_oe}, dir_m[15:0] & out_m[15:0]);
      lvl_m = (dir_m & out_m) | (~dir_m & {24'h000000, ext});
      rd_reg(EGP_LVL_ADDR, lvl_m[15:0]);
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
